// [shared/ucp_pkg.sv]
// Shared constants, types and helpers of the serial port control block.
package ucp_pkg;

  // Bus widths of the register slave.
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] CTRL_IDX = 8'hFD;
  localparam logic [7:0] FLAGS_IDX = 8'hFE;
  localparam logic [1:0] WORD_PAD = 2'h0;
  localparam logic [1:0] ADDR_TOP = 2'h0;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = {ADDR_TOP, CTRL_IDX, WORD_PAD};
  localparam logic [ADDR_W-1:0] FLAGS_ADDR = {ADDR_TOP, FLAGS_IDX, WORD_PAD};

  // Control register fields.
  localparam int unsigned CTRL_MODE_HI = 7;
  localparam int unsigned CTRL_MODE_LO = 6;
  localparam int unsigned CTRL_MPF = 5;
  localparam int unsigned CTRL_REN = 4;
  localparam int unsigned CTRL_TB9 = 3;
  localparam int unsigned CTRL_RB9 = 2;
  localparam int unsigned CTRL_RIE = 1;
  localparam int unsigned CTRL_TIE = 0;
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;

  // Pending register fields; the upper six bits are not implemented.
  localparam int unsigned FLG_RX = 1;
  localparam int unsigned FLG_TX = 0;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [5:0] FLAGS_UNUSED = 6'h00;
  localparam logic [REG_W-1:0] LANE_PAD_ZERO = 8'h00;
  localparam logic [DATA_W-REG_W-1:0] UPPER_ZERO = 24'h000000;

  // Operating modes as held in the two mode bits.
  typedef logic [1:0] ucp_mode_t;
  localparam ucp_mode_t MODE_SHIFT = 2'h0;
  localparam ucp_mode_t MODE_ASYNC8 = 2'h1;
  localparam ucp_mode_t MODE_ASYNC9_FIXED = 2'h2;
  localparam ucp_mode_t MODE_ASYNC9 = 2'h3;

  // Frame composition: data bits exclude the added start and stop bits.
  typedef logic [3:0] ucp_bits_t;
  localparam ucp_bits_t START_BITS = 4'h1;
  localparam ucp_bits_t STOP_BITS = 4'h1;
  localparam ucp_bits_t DATA8_BITS = 4'h8;
  localparam ucp_bits_t DATA9_BITS = 4'h9;
  localparam ucp_bits_t SHIFT_BITS = 4'h8;

  // Register slave states.
  typedef enum logic {UCP_APB_IDLE, UCP_APB_ANSWER} ucp_apb_state_t;

  // Line bits per frame for a mode, start and stop included when async.
  function automatic ucp_bits_t ucp_frame_bits(input ucp_mode_t mode);
    case (mode)
      MODE_SHIFT: ucp_frame_bits = SHIFT_BITS;
      MODE_ASYNC8: ucp_frame_bits = START_BITS + DATA8_BITS + STOP_BITS;
      default: ucp_frame_bits = START_BITS + DATA9_BITS + STOP_BITS;
    endcase
  endfunction : ucp_frame_bits

  // True for the two nine-bit asynchronous modes.
  function automatic logic ucp_is_nine(input ucp_mode_t mode);
    ucp_is_nine = (mode == MODE_ASYNC9) || (mode == MODE_ASYNC9_FIXED);
  endfunction : ucp_is_nine

endpackage : ucp_pkg

// [logic/ucp_rx_filter.sv]
// Multiprocessor receive filter that decides whether a frame may flag.
`timescale 1ns/1ps
module ucp_rx_filter (
  // Current configuration.
  input wire ucp_pkg::ucp_mode_t mode,
  input wire logic filter_en,
  // Status of the frame just received.
  input wire logic ninth_bit,
  input wire logic stop_ok,
  // Verdict.
  output logic accept
);
  import ucp_pkg::*;

  // With the filter off every frame passes; the shift mode never filters,
  // because the case default accepts every frame there whatever the filter bit.
  always_comb begin
    accept = 1'b1;
    if (filter_en) begin
      case (mode)
        MODE_ASYNC9, MODE_ASYNC9_FIXED: accept = ninth_bit;
        MODE_ASYNC8: accept = stop_ok;
        default: accept = 1'b1;
      endcase
    end
  end

endmodule : ucp_rx_filter

// [logic/ucp_top.sv]
// Serial port control and pending flags behind an APB register slave.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module ucp_top (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ucp_pkg::ADDR_W-1:0] paddr,
  input wire logic [ucp_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [ucp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Events from the shift engines on the same clock.
  input wire logic rx_frame_done,
  input wire logic rx_ninth_bit,
  input wire logic rx_stop_ok,
  input wire logic tx_frame_done,
  // Configuration towards the shift engines and baud generator.
  output ucp_pkg::ucp_mode_t serial_mode,
  output logic multiprocessor_filter_enable,
  output logic rx_enable,
  output logic tx_ninth_bit,
  output logic use_baud_divisor,
  output ucp_pkg::ucp_bits_t frame_bits,
  // Interrupt requests towards the core's interrupt logic.
  output logic rx_int_req,
  output logic tx_int_req
);
  import ucp_pkg::*;

  ucp_apb_state_t state_q;
  logic [REG_W-1:0] ctrl_q;
  logic rx_pend_q;
  logic tx_pend_q;
  logic [DATA_W-1:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic use_div_q;
  ucp_bits_t frame_bits_q;
  logic rx_req_q;
  logic tx_req_q;
  logic setup;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_flags;
  logic mapped;
  logic filter_ok;
  logic rx_accept;
  logic [REG_W-1:0] flags_view;

  // Address decode; only the two word addresses answer without error.
  assign mapped = (paddr == CTRL_ADDR) || (paddr == FLAGS_ADDR);
  assign setup = psel && !penable;
  // A write lands only at the edge that completes the access phase.
  assign wr_lane0 = psel && penable && pready_q && pwrite && pstrb[0];
  assign wr_ctrl = wr_lane0 && (paddr == CTRL_ADDR);
  assign wr_flags = wr_lane0 && (paddr == FLAGS_ADDR);
  // Unimplemented pending bits always read as zero.
  assign flags_view = {FLAGS_UNUSED, rx_pend_q, tx_pend_q};

  // Frame filter for the multiprocessor address scheme.
  ucp_rx_filter u_filter (
    .mode (ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO]),
    .filter_en (ctrl_q[CTRL_MPF]),
    .ninth_bit (rx_ninth_bit),
    .stop_ok (rx_stop_ok),
    .accept (filter_ok)
  );

  // Frames arriving while receive is disabled are dropped here as well.
  assign rx_accept = rx_frame_done && filter_ok &&
    ctrl_q[CTRL_REN];

  // Slave handshake: one setup cycle, then an access phase with pready.
  // Read data is captured at setup, so a flag set during the access phase
  // shows on the next read rather than this one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= UCP_APB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      case (state_q)
        UCP_APB_IDLE: begin
          if (setup) begin
            state_q <= UCP_APB_ANSWER;
            pready_q <= 1'b1;
            pslverr_q <= !mapped;
            if (pwrite || !mapped) begin
              prdata_q <= '0;
            end else if (paddr == CTRL_ADDR) begin
              prdata_q <= {UPPER_ZERO, ctrl_q};
            end else begin
              prdata_q <= {UPPER_ZERO, flags_view};
            end
          end
        end
        UCP_APB_ANSWER: begin
          state_q <= UCP_APB_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: begin
          state_q <= UCP_APB_IDLE;
          pready_q <= 1'b0;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  // Control register; the captured ninth bit is overwritten by hardware,
  // and a capture in the same cycle as a write wins over the write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[REG_W-1:0];
      end
      if (rx_accept && ucp_is_nine(ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO])) begin
        ctrl_q[CTRL_RB9] <= rx_ninth_bit;
      end
    end
  end

  // Receive pending flag; a new frame beats a clearing write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pend_q <= FLAG_RESET;
    end else if (rx_accept) begin
      rx_pend_q <= 1'b1;
    end else if (wr_flags) begin
      rx_pend_q <= pwdata[FLG_RX];
    end
  end

  // Transmit pending flag; a finished frame beats a clearing write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pend_q <= FLAG_RESET;
    end else if (tx_frame_done) begin
      tx_pend_q <= 1'b1;
    end else if (wr_flags) begin
      tx_pend_q <= pwdata[FLG_TX];
    end
  end

  // Mode decode for the baud generator and shift engines, one cycle late.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      use_div_q <= 1'b1;
      frame_bits_q <= SHIFT_BITS;
    end else begin
      use_div_q <= (ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO] !=
        MODE_ASYNC9_FIXED);
      frame_bits_q <=
        ucp_frame_bits(ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO]);
    end
  end

  // Interrupt requests are the pending flags gated by their enables.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_req_q <= 1'b0;
      tx_req_q <= 1'b0;
    end else begin
      rx_req_q <= rx_pend_q && ctrl_q[CTRL_RIE];
      tx_req_q <= tx_pend_q && ctrl_q[CTRL_TIE];
    end
  end

  // Outputs come straight from flip-flops.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_mode = ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO];
  assign multiprocessor_filter_enable = ctrl_q[CTRL_MPF];
  assign rx_enable = ctrl_q[CTRL_REN];
  assign tx_ninth_bit = ctrl_q[CTRL_TB9];
  assign use_baud_divisor = use_div_q;
  assign frame_bits = frame_bits_q;
  assign rx_int_req = rx_req_q;
  assign tx_int_req = tx_req_q;

  // Named steps of a register access.
  sequence s_setup;
    psel && !penable && state_q == UCP_APB_IDLE;
  endsequence

  sequence s_answer;
    pready_q && psel && penable;
  endsequence

  sequence s_flag_read;
    s_setup and (!pwrite && paddr == FLAGS_ADDR);
  endsequence

  // A setup cycle is answered in the very next cycle, for one cycle only.
  a_apb_ready_once: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup |=> pready_q ##1 !pready_q)
    else $error("pready not one cycle after setup");

  // A read of the pending word shows the flags and zero above them.
  a_flags_read_upper: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_read |=> prdata_q[DATA_W-1:FLG_RX+1] == '0 &&
      prdata_q[FLG_RX] == $past(rx_pend_q) &&
      prdata_q[FLG_TX] == $past(tx_pend_q))
    else $error("pending read value wrong");

  // A zero ninth bit under the filter in nine-bit modes never flags.
  a_rx_filter_ninth: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_frame_done && !wr_flags && ctrl_q[CTRL_MPF] && !rx_ninth_bit &&
      ucp_is_nine(ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO])
    |=> !$rose(rx_pend_q))
    else $error("receive flag raised despite zero ninth bit");

  // A missing stop bit under the filter in eight-bit mode never flags.
  a_rx_filter_stop: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_frame_done && !wr_flags && ctrl_q[CTRL_MPF] && !rx_stop_ok &&
      ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_ASYNC8
    |=> !$rose(rx_pend_q))
    else $error("receive flag raised despite bad stop bit");

  // An accepted frame sets the receive flag and, with enable, the request.
  a_rx_set_request: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_accept && ctrl_q[CTRL_RIE] && !wr_ctrl
    |=> rx_pend_q ##1 rx_req_q)
    else $error("receive flag or request missing");

  // Writing zero clears a receive flag unless a frame arrives with it.
  a_rx_clear_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_flags && !pwdata[FLG_RX] && !rx_accept |=> !rx_pend_q)
    else $error("receive flag not cleared by write");

  // Writing zero clears a transmit flag; a same-cycle event wins.
  a_tx_clear_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_flags && !pwdata[FLG_TX] |=> tx_pend_q == $past(tx_frame_done))
    else $error("transmit flag clear or set wrong");

  // Frame length follows the mode with start and stop bits added when async.
  a_frame_len_mode: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 frame_bits_q == ucp_frame_bits($past(serial_mode)))
    else $error("frame length does not match mode");

  // Only the fixed nine-bit mode bypasses the baud divisor.
  a_mode_divisor: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 use_div_q == ($past(serial_mode) != MODE_ASYNC9_FIXED))
    else $error("divisor selection does not match mode");

  // Unmapped addresses answer with an error and change no register.
  a_unmapped_error: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_setup and !mapped |=> pslverr_q && !wr_ctrl && !wr_flags)
    else $error("unmapped access not refused");

  // A finished transmit frame sets the flag and, with enable, the request.
  a_tx_set_request: assert property (
    @(posedge pclk) disable iff (!presetn)
    tx_frame_done && ctrl_q[CTRL_TIE] && !wr_ctrl
    |=> tx_pend_q ##1 tx_req_q)
    else $error("transmit flag or request missing");

  // A completed control write lands whole unless a capture hits bit 2.
  a_ctrl_write_lands: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_answer and (pwrite && pstrb[0] && paddr == CTRL_ADDR &&
      !rx_frame_done)
    |=> ctrl_q == $past(pwdata[REG_W-1:0]))
    else $error("control write did not land");

  // An accepted nine-bit frame leaves its ninth bit in control bit 2.
  a_rx_ninth_capture: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_accept && ucp_is_nine(ctrl_q[CTRL_MODE_HI:CTRL_MODE_LO])
    |=> ctrl_q[CTRL_RB9] == $past(rx_ninth_bit))
    else $error("received ninth bit not captured");

  // With receive disabled a finished frame never raises the flag.
  a_rx_disabled_drop: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_frame_done && !ctrl_q[CTRL_REN] && !wr_flags
    |=> !$rose(rx_pend_q))
    else $error("receive flag raised while receive disabled");

endmodule : ucp_top

// [sim/ucp_engine_model.sv]
// Behavioural receive and transmit engines that raise frame events.
`timescale 1ns/1ps
module ucp_engine_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Frame events towards the control block.
  output logic rx_frame_done,
  output logic rx_ninth_bit,
  output logic rx_stop_ok,
  output logic tx_frame_done
);
  logic rx_cmd = 1'b0;
  logic tx_cmd = 1'b0;
  logic ninth_cmd = 1'b0;
  logic stop_cmd = 1'b0;

  // Status lines toggle outside a pulse, so a stale value never looks valid.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_frame_done <= 1'b0;
      tx_frame_done <= 1'b0;
      rx_ninth_bit <= 1'b0;
      rx_stop_ok <= 1'b0;
    end else begin
      rx_frame_done <= rx_cmd;
      tx_frame_done <= tx_cmd;
      rx_ninth_bit <= rx_cmd ? ninth_cmd : ~rx_ninth_bit;
      rx_stop_ok <= rx_cmd ? stop_cmd : ~rx_stop_ok;
    end
  end

  // One frame event; an extra edge keeps back-to-back calls apart.
  task automatic send(input logic rx, input logic ninth, input logic stop);
    rx_cmd <= rx;
    tx_cmd <= ~rx;
    ninth_cmd <= ninth;
    stop_cmd <= stop;
    @(posedge pclk);
    rx_cmd <= 1'b0;
    tx_cmd <= 1'b0;
    @(posedge pclk);
  endtask : send
endmodule : ucp_engine_model

// [sim/ucp_top_tb.sv]
// Self-checking bench of the serial port control block.
`timescale 1ns/1ps
module ucp_top_tb;
  import ucp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic rxd, rx9, rxs, txd, ubd, rxq, txq;
  logic ren, tb9, mfe;
  ucp_mode_t smode;
  ucp_bits_t frame_bits;
  int fails = 0;
  int check_count = 0;
  // Rows: mode(2), filter, ninth bit, stop ok, expected receive flag.
  logic [5:0] rows [9] = '{6'h01, 6'h1C, 6'h1B, 6'h11, 6'h2A, 6'h2F,
                           6'h3A, 6'h3D, 6'h33};

  ucp_top i_ucp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_frame_done(rxd), .rx_ninth_bit(rx9), .rx_stop_ok(rxs),
    .tx_frame_done(txd), .serial_mode(smode),
    .multiprocessor_filter_enable(mfe), .rx_enable(ren),
    .tx_ninth_bit(tb9), .use_baud_divisor(ubd),
    .frame_bits(frame_bits), .rx_int_req(rxq), .tx_int_req(txq));

  ucp_engine_model i_ucp_engine_model (.pclk(pclk), .presetn(presetn),
    .rx_frame_done(rxd), .rx_ninth_bit(rx9), .rx_stop_ok(rxs),
    .tx_frame_done(txd));

  // Free-running bus clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One APB transfer; an idle edge follows so the next setup never collides.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until pready is seen high at a rising edge; only the
    // watchdog ends a wait that never gets an answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    test_done();
  end

  initial begin : main
    logic [5:0] r;
    logic [7:0] c;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state seen at the ports and through the bus.
    chk("frame_bits", 32'h8, 32'(frame_bits));
    chk("use_baud_divisor", 32'h1, 32'(ubd));
    apb(1'b0, CTRL_ADDR, 32'h0, 4'h0, rd, err);
    chk("control", 32'h0, rd);
    apb(1'b0, FLAGS_ADDR, 32'h0, 4'h0, rd, err);
    chk("flags", 32'h0, rd);
    // Each row sets mode and filter with receive and its request enabled.
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      c = {r[5:3], 1'b1, 2'h0, 1'b1, 1'b0};
      apb(1'b1, CTRL_ADDR, 32'(c), 4'hF, rd, err);
      apb(1'b1, FLAGS_ADDR, 32'h0, 4'hF, rd, err);
      i_ucp_engine_model.send(1'b1, r[2], r[1]);
      repeat (3) @(posedge pclk);
      chk("rx_int_req", 32'(r[0]), 32'(rxq));
      chk("serial_mode", 32'(r[5:4]), 32'(smode));
      chk("filter_enable", 32'(r[3]), 32'(mfe));
      chk("rx_enable", 32'h1, 32'(ren));
      // Start and stop add two line bits to the async data lengths.
      chk("frame_bits", (r[5:4] == MODE_SHIFT) ? 32'h8 :
          (r[5:4] == MODE_ASYNC8) ? 32'hA : 32'hB, 32'(frame_bits));
      chk("use_baud_divisor", 32'(r[5:4] != MODE_ASYNC9_FIXED),
          32'(ubd));
      c[2] = r[0] & r[5] & r[2];
      apb(1'b0, CTRL_ADDR, 32'h0, 4'h0, rd, err);
      chk("control", 32'(c), rd);
      apb(1'b0, FLAGS_ADDR, 32'h0, 4'h0, rd, err);
      chk("flags", 32'({r[0], 1'b0}), rd);
    end
    // Transmit flag with receive disabled, then clearing by writing zero.
    apb(1'b1, CTRL_ADDR, 32'h9, 4'hF, rd, err);
    apb(1'b1, FLAGS_ADDR, 32'h0, 4'hF, rd, err);
    i_ucp_engine_model.send(1'b1, 1'b1, 1'b1);
    i_ucp_engine_model.send(1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge pclk);
    chk("tx_int_req", 32'h1, 32'(txq));
    chk("rx_enable", 32'h0, 32'(ren));
    chk("tx_ninth_bit", 32'h1, 32'(tb9));
    apb(1'b0, FLAGS_ADDR, 32'h0, 4'h0, rd, err);
    chk("flags", 32'h1, rd);
    apb(1'b1, FLAGS_ADDR, 32'h0, 4'hF, rd, err);
    repeat (2) @(posedge pclk);
    chk("tx_int_req", 32'h0, 32'(txq));
    apb(1'b0, FLAGS_ADDR, 32'h0, 4'h0, rd, err);
    chk("flags", 32'h0, rd);
    // Upper pending bits hold nothing; a write without lane 0 is ignored.
    apb(1'b1, FLAGS_ADDR, 32'hFF, 4'hF, rd, err);
    apb(1'b1, FLAGS_ADDR, 32'h0, 4'h0, rd, err);
    apb(1'b0, FLAGS_ADDR, 32'h0, 4'h0, rd, err);
    chk("flags", 32'h3, rd);
    // Unmapped addresses are refused.
    apb(1'b0, 12'h000, 32'h0, 4'h0, rd, err);
    chk("pslverr", 32'h1, 32'(err));
    chk("unmapped read", 32'h0, rd);
    apb(1'b1, 12'h004, 32'hFF, 4'hF, rd, err);
    chk("pslverr", 32'h1, 32'(err));
    apb(1'b0, CTRL_ADDR, 32'h0, 4'h0, rd, err);
    chk("control", 32'h9, rd);
    chk("pslverr", 32'h0, 32'(err));
    // Reset in mid-run clears flags, control word and requests.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("tx_int_req", 32'h0, 32'(txq));
    chk("frame_bits", 32'h8, 32'(frame_bits));
    apb(1'b0, FLAGS_ADDR, 32'h0, 4'h0, rd, err);
    chk("flags", 32'h0, rd);
    apb(1'b0, CTRL_ADDR, 32'h0, 4'h0, rd, err);
    chk("control", 32'h0, rd);
    test_done();
  end
endmodule : ucp_top_tb
